// ---- fdcdp_top.sv ----
// floppy controller data path: fifo, host pacing, separator, precompensation
// Contract
// - sixteen byte fifo with programmable threshold
// - all command and disk bytes pass fifo
// - host moves bytes only per request/direction
// - any reset leaves fifo disabled
// - only configure command changes fifo settings
// - command phase treats fifo disabled, single bytes
// - flush fifo on entering execution
// - overrun or underrun ends command, transfer
// - write underrun pads zeros, valid crc
// - dma request only when dma selected
// - separator locks, window samples data/clock
// - serial to parallel clock and data bytes
// - every pulse synced and phase corrected (a pulse in the cycle the rate changes is synced but not phase corrected)
// - integrator tracks input data rate
// - precompensation shifts bits early or late
// - separator works up to two megabits
// - one command sets perpendicular mode
// - command, execution, result phases in order
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module fdcdp_top #(
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fdcdp_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // dma channel
  input wire logic dma_ack,
  input wire logic [7:0] dma_wdata,
  output logic [7:0] dma_rdata,
  output logic ldrq,
  // controller core
  input wire logic [1:0] core_phase,
  input wire logic core_dir_read,
  input wire logic core_wr_valid,
  input wire logic [7:0] core_wr_data,
  input wire logic core_rd_req,
  output logic core_rd_strobe,
  output logic [7:0] core_rd_data,
  output logic core_zero_fill,
  output logic core_terminate,
  output logic core_result_allowed,
  // command decode results from core
  input wire logic cfg_load,
  input wire logic cfg_efifo,
  input wire logic [3:0] cfg_thresh,
  input wire logic spec_load,
  input wire logic spec_dma,
  input wire logic perp_load,
  input wire logic perp_en,
  // read channel from drive
  input wire logic rd_pulse,
  output logic synced_read_data_pulse,
  output logic read_window_signal,
  output logic sep_byte_strobe,
  output logic [7:0] sep_clock_byte,
  output logic [7:0] sep_data_byte,
  // write channel to drive
  input wire logic wr_bit,
  input wire logic wr_bit_strobe,
  output logic wr_pulse
);
  import fdcdp_pkg::*;

  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

  function automatic logic is_mapped(input logic [APB_AW-1:0] a);
    return (a == MSR_OFS) || (a == DATA_OFS) || (a == RATE_OFS) ||
           (a == STAT_OFS) || (a == SEP_OFS);
  endfunction

  function automatic logic [9:0] nominal_half(input logic [1:0] r);
    case (r)
      RATE_500K: return HALF_500K_CYC;
      RATE_1M: return HALF_1M_CYC;
      RATE_250K: return HALF_250K_CYC;
      default: return HALF_2M_CYC;
    endcase
  endfunction

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [7:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic efifo_reg;
  logic [3:0] thresh_reg;
  logic dma_reg;
  logic perp_reg;
  logic [1:0] rate_reg;
  logic rqm_reg;
  logic dio_reg;
  logic overrun_reg;
  logic underrun_reg;
  logic [1:0] phase_prev_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic ldrq_reg;
  logic [7:0] dma_rdata_reg;
  logic core_rd_strobe_reg;
  logic [7:0] core_rd_data_reg;
  logic zero_fill_reg;
  logic terminate_reg;
  logic result_ok_reg;

  logic apb_commit;
  logic to_host;
  logic in_exec;
  logic exec_entry;
  logic cmd_entry;
  logic host_push;
  logic host_pop;
  logic dma_push;
  logic dma_pop;
  logic core_push;
  logic core_pop;
  logic push;
  logic pop;
  logic [7:0] push_data;
  logic overrun_evt;
  logic underrun_evt;
  logic [PW:0] thr_eff;
  logic svc;

  // ----------------------------------------
  // fifo control
  // ----------------------------------------
  assign apb_commit = psel && penable && pready_reg;
  assign in_exec = (core_phase == PH_EXEC);
  // result bytes and disk reads flow toward the host, the rest toward the core
  assign to_host = (core_phase == PH_RESULT) || (in_exec && core_dir_read);
  assign exec_entry = in_exec && (phase_prev_reg != PH_EXEC);
  assign cmd_entry = (core_phase == PH_CMD) && (phase_prev_reg != PH_CMD);

  // host bytes taken only while request and direction permit them
  assign host_push = apb_commit && pwrite && (paddr == DATA_OFS) && !to_host && rqm_reg;
  assign host_pop = apb_commit && !pwrite && (paddr == DATA_OFS) && to_host && rqm_reg;
  assign dma_push = dma_ack && dma_reg && in_exec && !to_host;
  assign dma_pop = dma_ack && dma_reg && in_exec && to_host && (count_reg != '0);
  assign core_push = core_wr_valid && to_host && (count_reg != DEPTH_C);
  assign core_pop = core_rd_req && !to_host && (count_reg != '0);
  assign push = ((host_push || dma_push) && (count_reg != DEPTH_C)) || core_push;
  assign pop = host_pop || dma_pop || core_pop;
  assign push_data = core_push ? core_wr_data : (dma_push ? dma_wdata : pwdata[7:0]);
  assign overrun_evt = in_exec && core_wr_valid && to_host && (count_reg == DEPTH_C);
  assign underrun_evt = in_exec && core_rd_req && !to_host && (count_reg == '0);

  // threshold field n means n+1 bytes; disabled mode behaves as one byte
  assign thr_eff = efifo_reg ? (PW+1)'({1'b0, thresh_reg} + 5'h01) : (PW+1)'(1);
  assign svc = to_host ? (count_reg >= thr_eff) : ((DEPTH_C - count_reg) >= thr_eff);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= push_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (exec_entry || cmd_entry) begin
      // stale bytes are dropped on entering command or execution phase; bytes left from execution stay for the result phase
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // ----------------------------------------
  // mode settings from decoded commands and the rate register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      efifo_reg <= EFIFO_RST;
      thresh_reg <= THRESH_RST;
    end else if (cfg_load) begin
      efifo_reg <= cfg_efifo;
      thresh_reg <= cfg_thresh;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      dma_reg <= DMA_RST;
    end else if (spec_load) begin
      dma_reg <= spec_dma;
    end
  end

  // perpendicular flag touches nothing but precompensation and its main status bit
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      perp_reg <= PERP_RST;
    end else if (perp_load) begin
      perp_reg <= perp_en;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rate_reg <= RATE_RST;
    end else if (apb_commit && pwrite && (paddr == RATE_OFS)) begin
      rate_reg <= pwdata[1:0];
    end
  end

  // ----------------------------------------
  // pacing: request, direction, dma request
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rqm_reg <= 1'b0;
      dio_reg <= 1'b0;
      ldrq_reg <= 1'b0;
      phase_prev_reg <= PH_IDLE;
      result_ok_reg <= 1'b1;
    end else begin
      phase_prev_reg <= core_phase;
      dio_reg <= to_host;
      result_ok_reg <= (count_reg == '0);
      ldrq_reg <= in_exec && dma_reg && svc && !terminate_reg;
      case (core_phase)
        // one parameter byte at a time, threshold ignored
        PH_CMD: rqm_reg <= (count_reg == '0) && !cmd_entry;
        PH_EXEC: rqm_reg <= !dma_reg && svc && !exec_entry;
        PH_RESULT: rqm_reg <= (count_reg != '0);
        default: rqm_reg <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // core side byte port and error handling
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      core_rd_strobe_reg <= 1'b0;
      core_rd_data_reg <= 8'h00;
      zero_fill_reg <= 1'b0;
      terminate_reg <= 1'b0;
      overrun_reg <= 1'b0;
      underrun_reg <= 1'b0;
    end else begin
      core_rd_strobe_reg <= core_pop || underrun_evt;
      terminate_reg <= (overrun_evt && !overrun_reg) || (underrun_evt && !underrun_reg);
      if (core_pop) begin
        core_rd_data_reg <= mem_reg[rd_ptr_reg];
      end else if (underrun_evt) begin
        // the sector is closed with zero bytes; core appends its crc
        core_rd_data_reg <= 8'h00;
      end
      // flags cleared at a new command unless an event lands that cycle
      if (overrun_evt) begin
        overrun_reg <= 1'b1;
      end else if (cmd_entry) begin
        overrun_reg <= 1'b0;
      end
      if (underrun_evt) begin
        underrun_reg <= 1'b1;
        zero_fill_reg <= 1'b1;
      end else if (cmd_entry) begin
        underrun_reg <= 1'b0;
        zero_fill_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      dma_rdata_reg <= 8'h00;
    end else if (dma_pop) begin
      dma_rdata_reg <= mem_reg[rd_ptr_reg];
    end
  end

  // ----------------------------------------
  // apb slave: one wait cycle, then answer
  // ----------------------------------------
  logic [7:0] sep_clk_byte_reg;
  logic [7:0] sep_dat_byte_reg;
  logic [7:0] msr_val;
  assign msr_val = {rqm_reg, dio_reg, in_exec, core_phase != PH_IDLE,
                    perp_reg, efifo_reg, dma_reg, 1'b0};

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && !is_mapped(paddr);
      if (psel && penable && !pready_reg) begin
        case (paddr)
          MSR_OFS: prdata_reg <= {24'h00_0000, msr_val};
          DATA_OFS: prdata_reg <= {24'h00_0000, mem_reg[rd_ptr_reg]};
          RATE_OFS: prdata_reg <= {30'h0000_0000, rate_reg};
          STAT_OFS: prdata_reg <= {16'h0000, thresh_reg, 2'b00, underrun_reg, overrun_reg,
                                   3'b000, 5'(count_reg)};
          SEP_OFS: prdata_reg <= {16'h0000, sep_clk_byte_reg, sep_dat_byte_reg};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // digital data separator
  // ----------------------------------------
  logic rd_prev_reg;
  logic pulse_reg;
  logic [9:0] half_reg;
  logic [9:0] win_cnt_reg;
  logic window_reg;
  logic seen_reg;
  logic [7:0] clk_sr_reg;
  logic [7:0] dat_sr_reg;
  logic [3:0] samp_cnt_reg;
  logic sep_strobe_reg;
  logic [1:0] rate_seen_reg;
  logic win_wrap;
  logic samp_bit;
  logic [9:0] center;
  logic signed [11:0] sep_err;
  logic [11:0] half_trk;
  logic [11:0] half_lo;
  logic [11:0] half_hi;
  logic [9:0] half_next;

  assign win_wrap = (win_cnt_reg >= half_reg - 10'h001);
  assign samp_bit = seen_reg || pulse_reg;
  assign center = half_reg >> 1;
  assign sep_err = signed'({2'b00, win_cnt_reg}) - signed'({2'b00, center});
  assign half_trk = 12'(signed'({2'b00, half_reg}) + (sep_err >>> SEP_GAIN));
  // tracking range held to one eighth of the nominal half cell either way
  assign half_lo = {2'b00, nominal_half(rate_reg) - (nominal_half(rate_reg) >> 3)};
  assign half_hi = {2'b00, nominal_half(rate_reg) + (nominal_half(rate_reg) >> 3)};
  assign half_next = (half_trk < half_lo) ? half_lo[9:0] :
                     ((half_trk > half_hi) ? half_hi[9:0] : half_trk[9:0]);

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rd_prev_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      rd_prev_reg <= rd_pulse;
      pulse_reg <= rd_pulse && !rd_prev_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      half_reg <= HALF_500K_CYC;
      rate_seen_reg <= RATE_RST;
      win_cnt_reg <= 10'h000;
      window_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      rate_seen_reg <= rate_reg;
      if (rate_seen_reg != rate_reg) begin
        half_reg <= nominal_half(rate_reg);
        win_cnt_reg <= 10'h000;
      end else if (pulse_reg) begin
        // phase snapped at once to the window centre, rate nudged slowly
        win_cnt_reg <= center;
        half_reg <= half_next;
        seen_reg <= 1'b1;
      end else if (win_wrap) begin
        win_cnt_reg <= 10'h000;
        window_reg <= !window_reg;
        seen_reg <= 1'b0;
      end else begin
        win_cnt_reg <= win_cnt_reg + 10'h001;
      end
    end
  end

  // window low samples the clock portion, window high the data portion
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      clk_sr_reg <= 8'h00;
      dat_sr_reg <= 8'h00;
      samp_cnt_reg <= 4'h0;
      sep_strobe_reg <= 1'b0;
      sep_clk_byte_reg <= 8'h00;
      sep_dat_byte_reg <= 8'h00;
    end else begin
      sep_strobe_reg <= 1'b0;
      if (win_wrap && !pulse_reg && (rate_seen_reg == rate_reg)) begin
        samp_cnt_reg <= samp_cnt_reg + 4'h1;
        if (window_reg) begin
          dat_sr_reg <= {dat_sr_reg[6:0], samp_bit};
        end else begin
          clk_sr_reg <= {clk_sr_reg[6:0], samp_bit};
        end
        if (samp_cnt_reg == 4'hf) begin
          sep_strobe_reg <= 1'b1;
          sep_clk_byte_reg <= clk_sr_reg;
          sep_dat_byte_reg <= {dat_sr_reg[6:0], samp_bit};
        end
      end
    end
  end

  // ----------------------------------------
  // write precompensation
  // ----------------------------------------
  fdcdp_pc_e pc_state_reg;
  logic [1:0] hist_reg;
  logic [7:0] pc_cnt_reg;
  logic wr_pulse_reg;
  logic [7:0] pc_delay;

  // a one after a one and before a zero is written early, one after a zero and before a one late
  always_comb begin
    pc_delay = 8'(2 * PRECOMP_STEP_CYC);
    if (!perp_reg && hist_reg[1] && !wr_bit) begin
      pc_delay = PRECOMP_STEP_CYC;
    end else if (!perp_reg && !hist_reg[1] && wr_bit) begin
      pc_delay = 8'(3 * PRECOMP_STEP_CYC);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pc_state_reg <= PC_IDLE;
      hist_reg <= 2'b00;
      pc_cnt_reg <= 8'h00;
      wr_pulse_reg <= 1'b0;
    end else begin
      wr_pulse_reg <= 1'b0;
      if (wr_bit_strobe) begin
        hist_reg <= {hist_reg[0], wr_bit};
      end
      case (pc_state_reg)
        PC_IDLE: begin
          if (wr_bit_strobe && hist_reg[0]) begin
            pc_cnt_reg <= pc_delay;
            pc_state_reg <= PC_DELAY;
          end
        end
        PC_DELAY: begin
          if (pc_cnt_reg <= 8'h01) begin
            wr_pulse_reg <= 1'b1;
            pc_state_reg <= PC_IDLE;
          end else begin
            pc_cnt_reg <= pc_cnt_reg - 8'h01;
          end
        end
        default: pc_state_reg <= PC_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign dma_rdata = dma_rdata_reg;
  assign ldrq = ldrq_reg;
  assign core_rd_strobe = core_rd_strobe_reg;
  assign core_rd_data = core_rd_data_reg;
  assign core_zero_fill = zero_fill_reg;
  assign core_terminate = terminate_reg;
  assign core_result_allowed = result_ok_reg;
  assign synced_read_data_pulse = pulse_reg;
  assign read_window_signal = window_reg;
  assign sep_byte_strobe = sep_strobe_reg;
  assign sep_clock_byte = sep_clk_byte_reg;
  assign sep_data_byte = sep_dat_byte_reg;
  assign wr_pulse = wr_pulse_reg;

endmodule

// ---- fdcdp_pkg.sv ----
// package: constants, offsets and types of the floppy data path
package fdcdp_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  // bit cell lengths per data rate select code
  localparam int unsigned CELL_500K_NS = 2000;
  localparam int unsigned CELL_1M_NS = 1000;
  localparam int unsigned CELL_250K_NS = 4000;
  localparam int unsigned CELL_2M_NS = 500;
  localparam logic [9:0] HALF_500K_CYC = 10'((CELL_500K_NS / CLK_PERIOD_NS) / 2);
  localparam logic [9:0] HALF_1M_CYC = 10'((CELL_1M_NS / CLK_PERIOD_NS) / 2);
  localparam logic [9:0] HALF_250K_CYC = 10'((CELL_250K_NS / CLK_PERIOD_NS) / 2);
  localparam logic [9:0] HALF_2M_CYC = 10'((CELL_2M_NS / CLK_PERIOD_NS) / 2);
  // write precompensation shift step
  localparam int unsigned PRECOMP_STEP_NS = 60;
  localparam logic [7:0] PRECOMP_STEP_CYC = 8'(PRECOMP_STEP_NS / CLK_PERIOD_NS);
  // separator integrator gain (right shift of phase error)
  localparam int unsigned SEP_GAIN = 4;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam int unsigned APB_AW = 8;
  localparam logic [7:0] MSR_OFS = 8'h00;
  localparam logic [7:0] DATA_OFS = 8'h04;
  localparam logic [7:0] RATE_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam logic [7:0] SEP_OFS = 8'h10;

  // main status bit positions
  localparam int unsigned MSR_RQM_BIT = 7;
  localparam int unsigned MSR_DIO_BIT = 6;
  localparam int unsigned MSR_EXEC_BIT = 5;
  localparam int unsigned MSR_BUSY_BIT = 4;
  localparam int unsigned MSR_PERP_BIT = 3;
  localparam int unsigned MSR_EFIFO_BIT = 2;
  localparam int unsigned MSR_DMA_BIT = 1;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic EFIFO_RST = 1'b0;
  localparam logic [3:0] THRESH_RST = 4'h0;
  localparam logic DMA_RST = 1'b0;
  localparam logic PERP_RST = 1'b0;
  localparam logic [1:0] RATE_RST = 2'h0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_CMD = 2'b01,
    PH_EXEC = 2'b10,
    PH_RESULT = 2'b11
  } fdcdp_phase_e;

  typedef enum logic [1:0] {
    RATE_500K = 2'b00,
    RATE_1M = 2'b01,
    RATE_250K = 2'b10,
    RATE_2M = 2'b11
  } fdcdp_rate_e;

  typedef enum logic [0:0] {
    PC_IDLE = 1'b0,
    PC_DELAY = 1'b1
  } fdcdp_pc_e;

endpackage

// ---- fdcdp_asserts.sv ----
// checker: port-level timing relations of the floppy data path
`timescale 1ns/1ps
module fdcdp_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // watched ports
  input wire logic pready,
  input wire logic ldrq,
  input wire logic spec_load,
  input wire logic spec_dma,
  input wire logic [1:0] core_phase,
  input wire logic rd_pulse,
  input wire logic synced_read_data_pulse,
  input wire logic core_rd_strobe,
  input wire logic [7:0] core_rd_data,
  input wire logic core_zero_fill,
  input wire logic core_terminate,
  input wire logic core_result_allowed
);
  import fdcdp_pkg::*;
  logic dma_mode_reg;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dma_mode_reg <= 1'h0;
    end else if (spec_load) begin
      dma_mode_reg <= spec_dma;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ldrq_dma_mode: assert property (ldrq |-> $past(dma_mode_reg))
    else $error("dma request outside dma mode");
  a_ldrq_in_exec: assert property (ldrq |-> $past(core_phase) == PH_EXEC)
    else $error("dma request outside execution");
  a_sync_follows: assert property ($rose(rd_pulse) |=> synced_read_data_pulse)
    else $error("read pulse not synced");
  a_sync_cause: assert property (synced_read_data_pulse |->
    $past(rd_pulse) && !$past(rd_pulse, 2)) else $error("synced pulse without cause");
  a_underrun_zero: assert property (core_rd_strobe && core_zero_fill |->
    core_rd_data == 8'h00) else $error("fill byte not zero");
  a_term_exec_pulse: assert property (core_terminate |->
    $past(core_phase) == PH_EXEC ##1 !core_terminate) else $error("bad terminate");
  a_flush_on_exec: assert property (core_phase == PH_EXEC &&
    $past(core_phase) != PH_EXEC |-> ##2 core_result_allowed) else $error("no flush");
  a_fill_clear_cmd: assert property (core_phase == PH_CMD &&
    $past(core_phase) != PH_CMD |=> !core_zero_fill) else $error("fill not cleared");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
endmodule
bind fdcdp_top fdcdp_asserts chk_i (.*);

// ---- fdcdp_dma_host.sv ----
// partner: host dma engine answering the device's request line
`timescale 1ns/1ps
module fdcdp_dma_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // request and pacing
  input wire logic ldrq,
  input wire logic slow,
  // acknowledge and byte
  output logic dma_ack,
  output logic [7:0] dma_wdata
);
  logic [3:0] gap_reg;
  logic [7:0] next_reg;
  // gap spans the request's registered lag
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_reg <= 4'h0;
      dma_ack <= 1'h0;
      next_reg <= 8'h40;
      dma_wdata <= 8'hbf;
    end else begin
      dma_ack <= 1'h0;
      dma_wdata <= ~dma_wdata;
      if (gap_reg != 4'h0) begin
        gap_reg <= gap_reg - 4'h1;
      end else if (ldrq) begin
        dma_ack <= 1'h1;
        dma_wdata <= next_reg;
        next_reg <= next_reg + 8'h01;
        gap_reg <= slow ? 4'h8 : 4'h3;
      end
    end
  end
endmodule

// ---- tb_floppy_fifo_datapath.sv ----
// testbench: fifo, dma, underrun and serial paths against a queue model
`timescale 1ns/1ps
module tb_floppy_fifo_datapath;
  import fdcdp_pkg::*;
  logic sys_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic core_dir_read = 1'h0, core_wr_valid = 1'h0, core_rd_req = 1'h0, cfg_load = 1'h0;
  logic cfg_efifo = 1'h0, spec_load = 1'h0, spec_dma = 1'h0, perp_load = 1'h0, perp_en = 1'h0;
  logic rd_pulse = 1'h0, wr_bit = 1'h0, wr_bit_strobe = 1'h0, slow = 1'h0;
  logic [1:0] core_phase = 2'h0;
  logic [3:0] cfg_thresh = 4'h0;
  logic [7:0] paddr = 8'h00, core_wr_data = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready, pslverr, dma_ack, ldrq, core_rd_strobe, core_zero_fill, core_terminate;
  logic core_result_allowed, synced_read_data_pulse, read_window_signal, sep_byte_strobe;
  logic wr_pulse, ev;
  logic ack_q = 1'h0, term_seen = 1'h0;
  logic [7:0] dma_wdata, dma_rdata, core_rd_data, sep_clock_byte, sep_data_byte;
  logic [31:0] prdata, rv;
  logic [15:0] lfsr = 16'h3f48;
  int errors = 0, tests_run = 0, syncs = 0, pulses = 0, ones = 0;
  logic [7:0] q[$];
  always #2 sys_clk = ~sys_clk;
  fdcdp_top dut (.*);
  fdcdp_dma_host host (.*);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      errors++;
      $display("unexpected %s exp %h seen %h", nm, x, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // idle cycle first so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      errors++;
      final_report();
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  always @(posedge sys_clk) begin
    ack_q <= dma_ack;
    if (ack_q) chk("dma_rdata", dma_rdata, q.pop_front());
    if (synced_read_data_pulse) syncs++;
    if (wr_pulse) pulses++;
    if (core_terminate) term_seen <= 1'h1;
    else if (spec_load) term_seen <= 1'h0;
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    tick(2);
    reset_n <= 1'h1;
    tick(3);
    apb(1'h0, MSR_OFS, 8'h00);
    chk("msr_modes", rv & 32'h0000_000e, 32'h0000_0000);
    apb(1'h0, STAT_OFS, 8'h00);
    chk("thresh", rv[15:12], THRESH_RST);
    apb(1'h0, 8'h14, 8'h00);
    chk("unmapped", {ev, rv[30:0]}, 32'h8000_0000);
    $display("test reset done");
    cfg_load <= 1'h1;
    cfg_efifo <= 1'h1;
    cfg_thresh <= 4'h3;
    spec_load <= 1'h1;
    spec_dma <= 1'h1;
    perp_load <= 1'h1;
    perp_en <= 1'h1;
    @(posedge sys_clk);
    cfg_load <= 1'h0;
    spec_load <= 1'h0;
    perp_load <= 1'h0;
    apb(1'h1, RATE_OFS, 8'h01);
    apb(1'h0, RATE_OFS, 8'h00);
    chk("rate", rv, RATE_1M);
    apb(1'h0, MSR_OFS, 8'h00);
    chk("msr_modes", rv & 32'h0000_000e, 32'h0000_000e);
    apb(1'h0, STAT_OFS, 8'h00);
    chk("thresh", rv[15:12], 4'h3);
    $display("test config done");
    core_phase <= PH_CMD;
    lfsr = nx(lfsr);
    tick(2);
    apb(1'h0, MSR_OFS, 8'h00);
    chk("rqm_dio", rv[7:6], 2'h2);
    apb(1'h1, DATA_OFS, lfsr[7:0]);
    apb(1'h0, MSR_OFS, 8'h00);
    chk("rqm_held", rv[7], 1'h0);
    core_rd_req <= 1'h1;
    @(posedge sys_clk);
    core_rd_req <= 1'h0;
    @(posedge sys_clk);
    chk("cmd_byte", {core_rd_strobe, core_rd_data}, {1'h1, lfsr[7:0]});
    $display("test command done");
    core_phase <= PH_EXEC;
    core_dir_read <= 1'h1;
    slow <= lfsr[0];
    tick(2);
    for (int i = 0; i < 6; i++) begin
      lfsr = nx(lfsr);
      core_wr_valid <= 1'h1;
      core_wr_data <= lfsr[7:0];
      q.push_back(lfsr[7:0]);
      @(posedge sys_clk);
    end
    core_wr_valid <= 1'h0;
    for (int n = 0; n < 500 && q.size() > 3; n++) tick(1);
    tick(40);
    chk("fifo_left", q.size(), 3);
    core_phase <= PH_RESULT;
    tick(2);
    repeat (3) begin
      apb(1'h0, DATA_OFS, 8'h00);
      chk("drain", rv, q.pop_front());
    end
    tick(2);
    chk("result_ok", core_result_allowed, 1'h1);
    $display("test dma read done");
    spec_load <= 1'h1;
    spec_dma <= 1'h0;
    core_phase <= PH_CMD;
    @(posedge sys_clk);
    spec_load <= 1'h0;
    core_phase <= PH_EXEC;
    core_dir_read <= 1'h0;
    tick(3);
    core_rd_req <= 1'h1;
    @(posedge sys_clk);
    core_rd_req <= 1'h0;
    @(posedge sys_clk);
    chk("fill_byte", {core_rd_strobe, core_rd_data}, 32'h0000_0100);
    tick(3);
    chk("underrun", {term_seen, core_zero_fill}, 2'h3);
    $display("test underrun done");
    for (int i = 0; i < 8; i++) begin
      rd_pulse <= 1'h1;
      tick(3);
      rd_pulse <= 1'h0;
      tick(122);
    end
    chk("sync_pulses", syncs, 8);
    for (int i = 0; i < 9; i++) begin
      lfsr = nx(lfsr);
      wr_bit <= lfsr[3] & (i < 8);
      ones += lfsr[3] & (i < 8);
      wr_bit_strobe <= 1'h1;
      @(posedge sys_clk);
      wr_bit_strobe <= 1'h0;
      tick(99);
    end
    chk("wr_pulses", pulses, ones);
    $display("test serial done");
    final_report();
  end
endmodule
